// >>> core/sgt_defines.svh
`ifndef SGT_DEFINES_SVH
`define SGT_DEFINES_SVH

// descriptor and selector field positions
`define SGT_D_P        47
`define SGT_D_S        44
`define SGT_D_CODE     43
`define SGT_D_L        53
`define SGT_SEL_TI     2

// system descriptor types
`define SGT_TY_LDT     4'h2
`define SGT_TY_TGATE   4'h5
`define SGT_TY_TSS_AV  4'h9
`define SGT_TY_TSS_BSY 4'hb
`define SGT_TY_CGATE   4'hc

// legacy task state layout, in 8-byte words
`define SGT_TW_SEG     5'h08
`define SGT_TW_FLG     5'h09
`define SGT_TW_IP      5'h0a
`define SGT_TW_LDT     5'h0b
`define SGT_TW_PB      5'h0c
`define SGT_TW_STK     5'h0d

// 64-bit task state layout, in 8-byte words
`define SGT_TW64_SP    5'h01
`define SGT_TW64_IST   5'h04
`define SGT_TW64_IOM   5'h0c

`endif

// >>> core/sgt_pkg.sv
`default_nettype none
package sgt_pkg;
   typedef enum logic [1:0] {M_REAL, M_PROT, M_COMPAT, M_LONG} sgt_mode_e;
   typedef enum logic [2:0] {
      C_MODE, C_LGDT, C_LLDT, C_LTR, C_XLATE, C_CALL
   } sgt_cmd_e;
   typedef enum logic [2:0] {
      S_IDLE, S_D0, S_D1, S_CHK, S_STK, S_SAVE, S_REST, S_IOM
   } sgt_state_e;
   typedef struct packed {
      sgt_state_e  st;
      sgt_mode_e   mode;
      sgt_cmd_e    cmd;
      logic [1:0]  ph;
      logic [15:0] sel;
      logic [15:0] nsel;
      logic [15:0] ldt_sel;
      logic [15:0] tr_sel;
      logic [15:0] cs;
      logic [15:0] ss;
      logic [63:0] global_descriptor_table;
      logic [63:0] local_descriptor_table;
      logic [63:0] tr;
      logic [63:0] nbase;
      logic [63:0] off;
      logic [63:0] ip;
      logic [63:0] sp;
      logic [63:0] flags;
      logic [63:0] pb;
      logic [63:0] iom;
      logic [63:0] dlo;
      logic [63:0] dhi;
      logic [63:0] addr;
      logic [63:0] lin;
      logic [63:0] gwd;
      logic [4:0]  cnt;
      logic [1:0]  current_privilege_level;
      logic [2:0]  gidx;
      logic        done;
      logic        fault;
      logic        gwe;
   } sgt_regs_s;
endpackage
`default_nettype wire

// >>> core/sgt_unit.sv
`include "sgt_defines.svh"
`default_nettype none
module sgt_unit (
   input  wire logic              i_sys_clk,        // core clock
   input  wire logic              i_rst_n,          // async reset, low
   input  wire logic              i_cmd_valid,      // command strobe
   input  wire sgt_pkg::sgt_cmd_e i_cmd,            // command code
   input  wire sgt_pkg::sgt_mode_e i_mode,          // target mode
   input  wire logic [15:0]       i_sel,            // selector operand
   input  wire logic [63:0]       i_offset,         // offset operand
   input  wire logic [63:0]       i_base,           // table base operand
   input  wire logic [63:0]       i_flags,          // live flags, saved
   input  wire logic [63:0]       i_ip,             // live pointer, saved
   output logic                   o_busy,           // command running
   output logic                   o_done,           // finished pulse
   output logic                   o_fault,          // protection fault
   output logic [63:0]            o_lin_addr,       // linear result
   output logic                   o_mem_req,        // memory request
   output logic                   o_mem_we,         // memory write
   output logic [63:0]            o_mem_addr,       // memory address
   output logic [63:0]            o_mem_wdata,      // memory write data
   input  wire logic              i_mem_ack,        // memory done
   input  wire logic [63:0]       i_mem_rdata,      // memory read data
   output logic [2:0]             o_gpr_rd_idx,     // register to save
   input  wire logic [63:0]       i_gpr_data,       // its value
   output logic                   o_gpr_we,         // restore strobe
   output logic [2:0]             o_gpr_wr_idx,     // restore index
   output logic [63:0]            o_gpr_wdata,      // restore value
   output sgt_pkg::sgt_mode_e     o_mode,           // operating mode
   output logic [1:0]             o_cpl,            // current privilege
   output logic [15:0]            o_cs_sel,         // code selector
   output logic [63:0]            o_ip,             // new pointer
   output logic [15:0]            o_ss_sel,         // stack selector
   output logic [63:0]            o_sp,             // stack pointer
   output logic [63:0]            o_flags,          // restored flags
   output logic [63:0]            o_paging_base,    // paging base
   output logic [63:0]            o_gdt_base,       // global table base
   output logic [15:0]            o_ldt_sel,        // local selector
   output logic [63:0]            o_ldt_base,       // local table base
   output logic [15:0]            o_tr_sel,         // task register
   output logic [63:0]            o_tr_base,        // task state base
   output logic [63:0]            o_io_bitmap_addr  // I/O bitmap address
);
   import sgt_pkg::*;

   sgt_regs_s   r_ff;
   sgt_regs_s   nxt_r;
   logic        ext;
   logic        d_p;
   logic        d_s;
   logic [3:0]  d_ty;
   logic [1:0]  d_dpl;
   logic [1:0]  rpl;
   logic [1:0]  eff;
   logic        tss_ty;
   logic [63:0] d_base;
   logic [63:0] g_off;
   logic [15:0] g_sel;
   logic [63:0] save_wd;
   logic        commit;

   function automatic logic [63:0] desc_addr(input logic [15:0] s);
      // selector TI bit picks the local table, clear picks the global one
      return (s[`SGT_SEL_TI] ? r_ff.local_descriptor_table : r_ff.global_descriptor_table) +
             {48'h0, s[15:3], 3'h0};
   endfunction

   function automatic logic is_null(input logic [15:0] s);
      return (s[15:3] == 13'h0) && !s[`SGT_SEL_TI];
   endfunction

   assign ext    = (r_ff.mode == M_COMPAT) || (r_ff.mode == M_LONG);
   assign d_p    = r_ff.dlo[`SGT_D_P];
   assign d_s    = r_ff.dlo[`SGT_D_S];
   assign d_ty   = r_ff.dlo[43:40];
   assign d_dpl  = r_ff.dlo[46:45];
   assign rpl    = r_ff.sel[1:0];
   assign eff    = (rpl > r_ff.current_privilege_level) ? rpl : r_ff.current_privilege_level;
   assign tss_ty = (d_ty == `SGT_TY_TSS_AV) || (d_ty == `SGT_TY_TSS_BSY);
   // upper half is zero unless a 16-byte descriptor was read
   assign d_base = {r_ff.dhi[31:0], r_ff.dlo[63:56], r_ff.dlo[39:16]};
   assign g_off  = {r_ff.dhi[31:0], r_ff.dlo[63:48], r_ff.dlo[15:0]};
   assign g_sel  = r_ff.dlo[31:16];

   // word written to the old task state during a switch
   always_comb begin
      if (r_ff.cnt < `SGT_TW_SEG)
         save_wd = i_gpr_data;
      else if (r_ff.cnt == `SGT_TW_SEG)
         save_wd = {32'h0, r_ff.cs, r_ff.ss};
      else if (r_ff.cnt == `SGT_TW_FLG)
         save_wd = i_flags;
      else if (r_ff.cnt == `SGT_TW_IP)
         save_wd = i_ip;
      else if (r_ff.cnt == `SGT_TW_LDT)
         save_wd = {48'h0, r_ff.ldt_sel};
      else
         save_wd = r_ff.pb;
   end

   always_comb begin
      nxt_r       = r_ff;
      nxt_r.done  = 1'b0;
      nxt_r.fault = 1'b0;
      nxt_r.gwe   = 1'b0;
      commit      = 1'b0;
      case (r_ff.st)
         S_IDLE: if (i_cmd_valid) begin
            nxt_r.cmd  = i_cmd;
            nxt_r.sel  = i_sel;
            nxt_r.off  = i_offset;
            nxt_r.ph   = 2'h0;
            nxt_r.done = 1'b1;
            if (i_cmd == C_MODE) begin
               // only real->protected->extended, software driven
               if ((r_ff.mode == M_REAL && i_mode == M_PROT) ||
                   (r_ff.mode == M_PROT && i_mode == M_COMPAT))
                  nxt_r.mode = i_mode;
               else
                  nxt_r.fault = 1'b1;
            end else if (i_cmd == C_LGDT) begin
               nxt_r.global_descriptor_table = ext ? i_base
                               : {32'h0, i_base[31:0]};
            end else if (r_ff.mode == M_REAL) begin
               if (i_cmd == C_XLATE)
                  nxt_r.lin = {44'h0, i_sel, 4'h0} + i_offset;
               else
                  nxt_r.fault = 1'b1;
            end else if (is_null(i_sel)) begin
               nxt_r.fault = 1'b1;
            end else begin
               nxt_r.done = 1'b0;
               nxt_r.addr = desc_addr(i_sel);
               nxt_r.st   = S_D0;
            end
            nxt_r.done = nxt_r.done && !nxt_r.fault;
         end
         S_D0: if (i_mem_ack) begin
            nxt_r.dlo = i_mem_rdata;
            nxt_r.dhi = 64'h0;
            // compat keeps legacy size; 64-bit widens system entries
            if (r_ff.mode == M_LONG && !i_mem_rdata[`SGT_D_S]) begin
               nxt_r.addr = r_ff.addr + 64'h8;
               nxt_r.st   = S_D1;
            end else begin
               nxt_r.st = S_CHK;
            end
         end
         S_D1: if (i_mem_ack) begin
            nxt_r.dhi = i_mem_rdata;
            nxt_r.st  = S_CHK;
         end
         S_CHK: begin
            nxt_r.st    = S_IDLE;
            nxt_r.fault = 1'b1;
            case (r_ff.cmd)
               C_XLATE: if (d_p && d_s && d_dpl >= eff) begin
                  nxt_r.lin   = d_base + r_ff.off;
                  nxt_r.fault = 1'b0;
                  nxt_r.done  = 1'b1;
               end
               C_LLDT: if (d_p && !d_s && d_ty == `SGT_TY_LDT &&
                           !r_ff.sel[`SGT_SEL_TI]) begin
                  nxt_r.local_descriptor_table     = d_base;
                  nxt_r.ldt_sel = r_ff.sel;
                  nxt_r.fault   = 1'b0;
                  nxt_r.done    = 1'b1;
               end
               C_LTR: if (d_p && !d_s && tss_ty &&
                          !r_ff.sel[`SGT_SEL_TI]) begin
                  nxt_r.tr_sel = r_ff.sel;
                  nxt_r.tr     = d_base;
                  nxt_r.fault  = 1'b0;
                  if (ext) begin
                     nxt_r.addr = d_base +
                        {56'h0, `SGT_TW64_IOM, 3'h0};
                     nxt_r.st   = S_IOM;
                  end else begin
                     nxt_r.done = 1'b1;
                  end
               end
               C_CALL: case (r_ff.ph)
                  2'h0: if (d_p && !d_s && eff <= d_dpl) begin
                     if (d_ty == `SGT_TY_CGATE && !is_null(g_sel)) begin
                        nxt_r.off   = g_off;
                        nxt_r.sel   = g_sel;
                        nxt_r.ph    = 2'h1;
                        nxt_r.addr  = desc_addr(g_sel);
                        nxt_r.st    = S_D0;
                        nxt_r.fault = 1'b0;
                     end else if (d_ty == `SGT_TY_TGATE && !ext &&
                                  !is_null(g_sel)) begin
                        nxt_r.sel   = g_sel;
                        nxt_r.ph    = 2'h2;
                        nxt_r.addr  = desc_addr(g_sel);
                        nxt_r.st    = S_D0;
                        nxt_r.fault = 1'b0;
                     end else if (tss_ty && !ext &&
                                  !r_ff.sel[`SGT_SEL_TI]) begin
                        nxt_r.nsel  = r_ff.sel;
                        nxt_r.nbase = d_base;
                        nxt_r.cnt   = 5'h0;
                        nxt_r.addr  = r_ff.tr;
                        nxt_r.st    = S_SAVE;
                        nxt_r.fault = 1'b0;
                     end
                  end
                  2'h1: if (d_p && d_s && r_ff.dlo[`SGT_D_CODE] &&
                            d_dpl <= r_ff.current_privilege_level) begin
                     nxt_r.fault = 1'b0;
                     nxt_r.nbase = d_base + r_ff.off;
                     if (d_dpl < r_ff.current_privilege_level) begin
                        // stack for the target level from current task
                        nxt_r.addr = r_ff.tr + {56'h0, (ext ?
                           `SGT_TW64_SP + {3'h0, d_dpl} :
                           `SGT_TW_STK + {3'h0, d_dpl}), 3'h0};
                        nxt_r.st   = S_STK;
                     end else begin
                        commit = 1'b1;
                     end
                  end
                  default: if (d_p && !d_s && tss_ty && !ext &&
                               !r_ff.sel[`SGT_SEL_TI]) begin
                     nxt_r.nsel  = r_ff.sel;
                     nxt_r.nbase = d_base;
                     nxt_r.cnt   = 5'h0;
                     nxt_r.addr  = r_ff.tr;
                     nxt_r.st    = S_SAVE;
                     nxt_r.fault = 1'b0;
                  end
               endcase
               default: nxt_r.fault = 1'b1;
            endcase
         end
         S_STK: if (i_mem_ack) begin
            if (ext) begin
               nxt_r.ss = 16'h0;
               nxt_r.sp = i_mem_rdata;
            end else begin
               nxt_r.ss = i_mem_rdata[63:48];
               nxt_r.sp = {32'h0, i_mem_rdata[31:0]};
            end
            commit = 1'b1;
         end
         S_SAVE: if (i_mem_ack) begin
            if (r_ff.cnt == `SGT_TW_PB) begin
               // old state is out; now the new task owns the register
               nxt_r.tr_sel = r_ff.nsel;
               nxt_r.tr     = r_ff.nbase;
               nxt_r.addr   = r_ff.nbase;
               nxt_r.cnt    = 5'h0;
               nxt_r.st     = S_REST;
            end else begin
               nxt_r.addr = r_ff.addr + 64'h8;
               nxt_r.cnt  = r_ff.cnt + 5'h1;
            end
         end
         S_REST: if (i_mem_ack) begin
            nxt_r.addr = r_ff.addr + 64'h8;
            nxt_r.cnt  = r_ff.cnt + 5'h1;
            if (r_ff.cnt < `SGT_TW_SEG) begin
               nxt_r.gwe  = 1'b1;
               nxt_r.gidx = r_ff.cnt[2:0];
               nxt_r.gwd  = i_mem_rdata;
            end else if (r_ff.cnt == `SGT_TW_SEG) begin
               nxt_r.cs  = i_mem_rdata[31:16];
               nxt_r.ss  = i_mem_rdata[15:0];
               nxt_r.current_privilege_level = i_mem_rdata[17:16];
            end else if (r_ff.cnt == `SGT_TW_FLG) begin
               nxt_r.flags = i_mem_rdata;
            end else if (r_ff.cnt == `SGT_TW_IP) begin
               nxt_r.ip = i_mem_rdata;
            end else if (r_ff.cnt == `SGT_TW_LDT) begin
               nxt_r.ldt_sel = i_mem_rdata[15:0];
               nxt_r.local_descriptor_table     = 64'h0;
            end else begin
               nxt_r.pb = i_mem_rdata;
               nxt_r.st = S_IDLE;
               // local table base follows by a fresh descriptor fetch
               if (is_null(r_ff.ldt_sel)) begin
                  nxt_r.done = 1'b1;
               end else begin
                  nxt_r.cmd  = C_LLDT;
                  nxt_r.sel  = r_ff.ldt_sel;
                  nxt_r.ph   = 2'h0;
                  nxt_r.addr = desc_addr(r_ff.ldt_sel);
                  nxt_r.st   = S_D0;
               end
            end
         end
         S_IOM: if (i_mem_ack) begin
            nxt_r.iom  = r_ff.tr + {48'h0, i_mem_rdata[63:48]};
            nxt_r.done = 1'b1;
            nxt_r.st   = S_IDLE;
         end
         default: nxt_r.st = S_IDLE;
      endcase
      if (commit) begin
         nxt_r.cs    = {r_ff.sel[15:2], d_dpl};
         nxt_r.ip    = r_ff.off;
         nxt_r.current_privilege_level   = d_dpl;
         nxt_r.lin   = nxt_r.nbase;
         if (ext)
            nxt_r.mode = r_ff.dlo[`SGT_D_L] ? M_LONG : M_COMPAT;
         nxt_r.done  = 1'b1;
         nxt_r.st    = S_IDLE;
      end
   end

   // every field resets to zero: real mode, idle, no fault
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         r_ff <= '0;
      else
         r_ff <= nxt_r;
   end

   assign o_busy           = (r_ff.st != S_IDLE);
   assign o_done           = r_ff.done;
   assign o_fault          = r_ff.fault;
   assign o_lin_addr       = r_ff.lin;
   assign o_mem_req        = (r_ff.st != S_IDLE) && (r_ff.st != S_CHK);
   assign o_mem_we         = (r_ff.st == S_SAVE);
   assign o_mem_addr       = r_ff.addr;
   assign o_mem_wdata      = save_wd;
   assign o_gpr_rd_idx     = r_ff.cnt[2:0];
   assign o_gpr_we         = r_ff.gwe;
   assign o_gpr_wr_idx     = r_ff.gidx;
   assign o_gpr_wdata      = r_ff.gwd;
   assign o_mode           = r_ff.mode;
   assign o_cpl            = r_ff.current_privilege_level;
   assign o_cs_sel         = r_ff.cs;
   assign o_ip             = r_ff.ip;
   assign o_ss_sel         = r_ff.ss;
   assign o_sp             = r_ff.sp;
   assign o_flags          = r_ff.flags;
   assign o_paging_base    = r_ff.pb;
   assign o_gdt_base       = r_ff.global_descriptor_table;
   assign o_ldt_sel        = r_ff.ldt_sel;
   assign o_ldt_base       = r_ff.local_descriptor_table;
   assign o_tr_sel         = r_ff.tr_sel;
   assign o_tr_base        = r_ff.tr;
   assign o_io_bitmap_addr = r_ff.iom;
endmodule // sgt_unit
`default_nettype wire

// >>> tb/sgt_unit_assertions.sv
`default_nettype none
module sgt_unit_assertions (
   input wire logic               i_sys_clk,   // core clock
   input wire logic               i_rst_n,     // async reset, low
   input wire logic               i_cmd_valid, // command strobe
   input wire logic               o_busy,      // running
   input wire logic               o_done,      // done pulse
   input wire logic               o_fault,     // fault pulse
   input wire logic [63:0]        o_lin_addr,  // linear result
   input wire logic               o_mem_req,   // memory request
   input wire logic               o_mem_we,    // memory write
   input wire logic [63:0]        o_mem_addr,  // memory address
   input wire logic               i_mem_ack,   // memory done
   input wire sgt_pkg::sgt_mode_e o_mode,      // operating mode
   input wire logic [1:0]         o_cpl,       // privilege
   input wire logic [15:0]        o_ss_sel,    // stack selector
   input wire logic [63:0]        o_gdt_base   // global table base
);
   import sgt_pkg::*;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_taken;
      i_cmd_valid && !o_busy;
   endsequence
   sequence s_answer;
      ##[1:400] (o_done || o_fault);
   endsequence
   a_cmd_answered: assert property (s_taken |-> s_answer)
      else $error("command got no answer");
   a_done_excl: assert property (!(o_done && o_fault))
      else $error("done and fault together");
   a_done_pulse: assert property (o_done |=> !o_done)
      else $error("done held too long");
   a_reset_real: assert property ($rose(i_rst_n) |-> o_mode == M_REAL)
      else $error("not in real mode after reset");
   a_mode_step: assert property ($changed(o_mode) |->
      ($past(o_mode) == M_REAL && o_mode == M_PROT) ||
      ($past(o_mode) == M_PROT && o_mode == M_COMPAT) ||
      ($past(o_mode) inside {M_COMPAT, M_LONG} && o_mode inside {M_COMPAT, M_LONG}))
      else $error("illegal mode step");
   a_req_hold: assert property (o_mem_req && !i_mem_ack |=>
      o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we))
      else $error("memory request dropped or moved");
   a_no_ext_save: assert property (o_mode inside {M_COMPAT, M_LONG} |->
      !(o_mem_req && o_mem_we)) else $error("task save in extended mode");
   a_null_stack: assert property (o_mode inside {M_COMPAT, M_LONG} &&
      $changed(o_cpl) |-> o_ss_sel == 16'h0) else $error("stack not null");
   a_lin_on_done: assert property ($changed(o_lin_addr) |-> o_done)
      else $error("linear address moved without done");
   a_fault_keeps: assert property (o_fault |->
      $stable(o_mode) && $stable(o_gdt_base)) else $error("fault changed state");
   a_gdt_on_done: assert property ($changed(o_gdt_base) |-> o_done)
      else $error("table base moved without done");
endmodule // sgt_unit_assertions
bind sgt_unit sgt_unit_assertions chk_u (.i_sys_clk, .i_rst_n, .i_cmd_valid,
   .o_busy, .o_done, .o_fault, .o_lin_addr, .o_mem_req, .o_mem_we,
   .o_mem_addr, .i_mem_ack, .o_mode, .o_cpl, .o_ss_sel, .o_gdt_base);
`default_nettype wire

// >>> tb/sgt_unit_tb_top.sv
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("wrong value at %0t got %h exp %h", $time, a, b); end end
module sgt_unit_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import sgt_pkg::*;
   logic        i_sys_clk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic        i_cmd_valid = 1'b0;
   sgt_cmd_e    i_cmd = C_MODE;
   sgt_mode_e   i_mode = M_REAL;
   logic [15:0] i_sel = 16'h0;
   logic [63:0] i_offset = 64'h0;
   logic [63:0] i_base = 64'h0;
   logic        i_mem_ack = 1'b0;
   logic [63:0] i_mem_rdata = 64'h0;
   logic        o_busy, o_done, o_fault, o_mem_req, o_mem_we;
   logic [63:0] o_lin_addr, o_mem_addr, o_mem_wdata, o_ip, o_gdt_base;
   logic [15:0] o_cs_sel, o_tr_sel;
   logic [63:0] o_tr_base, o_ldt_base, o_io_bitmap_addr;
   sgt_mode_e   o_mode;
   logic [63:0] mem [0:511];
   int          n_mismatch = 0;
   int          n_checks = 0;
   logic        flt;
   always #12.5 i_sys_clk = ~i_sys_clk;
   // memory answers one edge after a request; idle data is scrambled
   always @(posedge i_sys_clk) begin
      i_mem_ack <= o_mem_req && !i_mem_ack;
      i_mem_rdata <= (o_mem_req && !i_mem_ack) ? mem[o_mem_addr[11:3]]
                                               : ~i_mem_rdata;
      if (o_mem_req && i_mem_ack && o_mem_we) begin
         mem[o_mem_addr[11:3]] <= o_mem_wdata;
      end
   end
   sgt_unit dut_u (.i_sys_clk, .i_rst_n, .i_cmd_valid, .i_cmd, .i_mode,
      .i_sel, .i_offset, .i_base, .i_flags(64'h0), .i_ip(64'h0), .o_busy,
      .o_done, .o_fault, .o_lin_addr, .o_mem_req, .o_mem_we, .o_mem_addr,
      .o_mem_wdata, .i_mem_ack, .i_mem_rdata, .o_gpr_rd_idx(),
      .i_gpr_data(64'h0), .o_gpr_we(), .o_gpr_wr_idx(), .o_gpr_wdata(),
      .o_mode, .o_cpl(), .o_cs_sel, .o_ip, .o_ss_sel(), .o_sp(), .o_flags(),
      .o_paging_base(), .o_gdt_base, .o_ldt_sel(), .o_ldt_base,
      .o_tr_sel, .o_tr_base, .o_io_bitmap_addr);
   function automatic logic [63:0] seg(input logic [31:0] b,
                                       input logic [7:0] at, input logic l);
      return {b[31:24], 2'b00, l, 5'h0, at, b[23:0], 16'h0};
   endfunction
   function automatic logic [63:0] gate(input logic [15:0] s,
                                        input logic [31:0] o,
                                        input logic [7:0] at);
      return {o[31:16], at, 8'h0, s, o[15:0]};
   endfunction
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic run(input sgt_cmd_e c, input sgt_mode_e m,
                      input logic [15:0] s, input logic [63:0] v);
      int i;
      @(posedge i_sys_clk);
      i_cmd_valid <= 1'b1;
      i_cmd <= c;
      i_mode <= m;
      i_sel <= s;
      i_offset <= v;
      i_base <= v;
      @(posedge i_sys_clk);
      i_cmd_valid <= 1'b0;
      for (i = 0; i < 400; i++) begin
         @(negedge i_sys_clk);
         if (o_done === 1'b1 || o_fault === 1'b1) begin
            break;
         end
      end
      flt = o_fault;
      if (i == 400) begin
         n_mismatch++;
         $display("wrong value at %0t got %h exp %h", $time, o_done, 1'b1);
         end_of_test();
      end
   endtask
   task automatic t_modes();
      `CHK(o_mode, M_REAL);
      run(C_CALL, M_REAL, 16'h0028, 64'h0);
      `CHK(flt, 1'b1);
      run(C_MODE, M_COMPAT, 16'h0, 64'h0);
      `CHK(flt, 1'b1);
      `CHK(o_mode, M_REAL);
      run(C_MODE, M_PROT, 16'h0, 64'h0);
      `CHK(o_mode, M_PROT);
      $display("test modes done");
   endtask
   task automatic t_xlate();
      run(C_LGDT, M_PROT, 16'h0, 64'h100);
      `CHK(o_gdt_base, 64'h100);
      run(C_XLATE, M_PROT, 16'h000b, 64'h40);
      `CHK(flt, 1'b0);
      `CHK(o_lin_addr, 64'h10040);
      run(C_XLATE, M_PROT, 16'h0013, 64'h80);
      `CHK(flt, 1'b1);
      `CHK(o_lin_addr, 64'h10040);
      run(C_XLATE, M_PROT, 16'h001b, 64'h80);
      `CHK(flt, 1'b1);
      run(C_XLATE, M_PROT, 16'h0000, 64'h80);
      `CHK(flt, 1'b1);
      // same index via the empty local table must not succeed
      run(C_XLATE, M_PROT, 16'h000f, 64'h80);
      `CHK(flt, 1'b1);
      $display("test xlate done");
   endtask
   task automatic t_call();
      run(C_CALL, M_PROT, 16'h0028, 64'h0);
      `CHK(flt, 1'b0);
      `CHK(o_cs_sel, 16'h0020);
      `CHK(o_ip, 64'h15678);
      run(C_CALL, M_PROT, 16'h0033, 64'h0);
      `CHK(flt, 1'b1);
      `CHK(o_cs_sel, 16'h0020);
      $display("test call done");
   endtask
   task automatic t_ext();
      run(C_MODE, M_COMPAT, 16'h0, 64'h0);
      `CHK(o_mode, M_COMPAT);
      run(C_CALL, M_COMPAT, 16'h0040, 64'h0);
      `CHK(o_mode, M_LONG);
      `CHK(o_cs_sel, 16'h0038);
      `CHK(o_ip, 64'h9abc);
      run(C_CALL, M_LONG, 16'h0048, 64'h0);
      `CHK(flt, 1'b1);
      run(C_CALL, M_LONG, 16'h0058, 64'h0);
      `CHK(o_ip, 64'h2_0000_1111);
      run(C_MODE, M_PROT, 16'h0, 64'h0);
      `CHK(flt, 1'b1);
      run(C_LGDT, M_LONG, 16'h0, 64'hffff_0000_0000_0100);
      `CHK(o_gdt_base, 64'hffff_0000_0000_0100);
      // task register load in 64-bit sub-mode reads the bitmap offset
      run(C_LTR, M_LONG, 16'h0068, 64'h0);
      `CHK(flt, 1'b0);
      `CHK(o_tr_sel, 16'h0068);
      `CHK(o_tr_base, 64'h1_0000_0400);
      `CHK(o_io_bitmap_addr, 64'h1_0000_0468);
      run(C_LLDT, M_LONG, 16'h0078, 64'h0);
      `CHK(flt, 1'b0);
      `CHK(o_ldt_base, 64'h3_0000_0800);
      $display("test extended done");
   endtask
   initial begin
      for (int k = 0; k < 512; k++) begin
         mem[k] = 64'h0;
      end
      mem[9'h21] = seg(32'h0001_0000, 8'hf2, 1'b0);
      mem[9'h22] = seg(32'h0001_0000, 8'h72, 1'b0);
      mem[9'h23] = seg(32'h0, 8'h92, 1'b0);
      mem[9'h24] = seg(32'h0, 8'h9a, 1'b0);
      mem[9'h25] = gate(16'h0020, 32'h0001_5678, 8'hec);
      mem[9'h26] = gate(16'h0020, 32'h0001_5678, 8'h8c);
      mem[9'h27] = seg(32'h0, 8'h9a, 1'b1);
      mem[9'h28] = gate(16'h0038, 32'h0000_9abc, 8'h8c);
      mem[9'h29] = gate(16'h0038, 32'h0, 8'h85);
      mem[9'h2b] = gate(16'h0038, 32'h0000_1111, 8'h8c);
      mem[9'h2c] = 64'h2;
      mem[9'h2d] = seg(32'h0000_0400, 8'h89, 1'b0);
      mem[9'h2e] = 64'h1;
      mem[9'h2f] = seg(32'h0000_0800, 8'h82, 1'b0);
      mem[9'h30] = 64'h3;
      mem[9'h8c] = {16'h0068, 48'h0};
      repeat (8) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      t_modes();
      t_xlate();
      t_call();
      t_ext();
      end_of_test();
   end
endmodule // sgt_unit_tb_top
`default_nettype wire
